//--- hw/pwm_timer_map.svh
// Constants for the PWM input measuring timer: field positions, reset values and counts.
`ifndef PWM_TIMER_MAP_SVH
`define PWM_TIMER_MAP_SVH

// ----------------------------------------------------------------
// Control register one field positions
// ----------------------------------------------------------------
`define CR1_COUNT_EN_BIT   0
`define CR1_DIR_LSB        4
`define CR1_DIR_MSB        5
`define CR1_CLKDIV_LSB     8
`define CR1_CLKDIV_MSB     9
`define CR1_WIDE_BIT       10

// ----------------------------------------------------------------
// Interrupt enable register field positions
// ----------------------------------------------------------------
`define IEN_UPDATE_BIT     0
`define IEN_CAPTURE_BIT    1
`define IEN_TRIGGER_BIT    6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CR1_RESET          16'h0000
`define IEN_RESET          16'h0000
`define PERIOD_RESET       32'hffffffff
`define PRESC_RESET        16'h0000

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define NARROW_WIDTH       16
`define WIDE_WIDTH         32
`define FILTER_DIV_MAX     4

`endif

//--- hw/pwm_timer_pkg.sv
// Types shared by the PWM input measuring timer.
package pwm_timer_pkg;

  // Counter direction modes
  typedef enum logic [1:0] {
    DIR_UP,
    DIR_DOWN,
    DIR_UPDOWN,
    DIR_UPDOWN_ALT
  } count_dir_t;

  // Clock source and slave modes
  typedef enum logic [1:0] {
    SRC_INTERNAL,
    SRC_EXTERNAL,
    SRC_GATED
  } clock_mode_t;

  // Configuration carried as one group
  typedef struct packed {
    logic        count_en;
    count_dir_t  dir;
    logic [1:0]  clk_div;
    logic        wide_en;
    clock_mode_t clk_mode;
    logic        gate_level;
    logic        capture_en;
    logic        capture_rise;
    logic [15:0] presc;
    logic [31:0] period;
    logic [7:0]  repeat_count;
    logic        ien_update;
    logic        ien_trigger;
    logic        ien_capture;
  } timer_cfg_t;

  // Event flags reported by the timer
  typedef struct packed {
    logic update;
    logic trigger;
    logic capture;
  } timer_flags_t;

endpackage

//--- hw/pwm_input_sampler.sv
// Input sampler: divided sampling clock, filtered level and edge detection.
`timescale 1ns/10ps
`include "pwm_timer_map.svh"

module pwm_input_sampler #(
  parameter int DIV_W = 2
) (
  input  wire logic             i_clock,
  input  wire logic             i_resetn,
  input  wire logic [DIV_W-1:0] i_clk_div,
  input  wire logic             i_pin,
  output logic                  o_level,
  output logic                  o_rise,
  output logic                  o_fall,
  output logic                  o_sample_tick
);

  // ----------------------------------------------------------------
  // Sampling divider and filter
  // ----------------------------------------------------------------
  logic [2:0] div_cnt_reg,  div_cnt_next;   // Sample clock divider
  logic [1:0] hist_reg,     hist_next;      // Last two samples
  logic       level_reg,    level_next;     // Filtered level
  logic       rise_reg,     rise_next;      // Rising edge pulse
  logic       fall_reg,     fall_next;      // Falling edge pulse
  logic       tick_reg,     tick_next;      // Sample enable pulse
  logic [2:0] div_limit;                    // Divide factor minus one

  // Division 1, 2 or 4; code 3 is treated as 4
  always_comb begin
    case (i_clk_div)
      2'd0:    div_limit = 3'd0;
      2'd1:    div_limit = 3'd1;
      default: div_limit = 3'(`FILTER_DIV_MAX - 1);
    endcase
  end

  // Two equal samples are needed before the level moves; trades one
  // sample period of delay for immunity to single-sample glitches.
  always_comb begin
    div_cnt_next = div_cnt_reg;
    hist_next    = hist_reg;
    level_next   = level_reg;
    rise_next    = 1'b0;
    fall_next    = 1'b0;
    tick_next    = 1'b0;
    if (div_cnt_reg >= div_limit) begin // Sample point
      div_cnt_next = 3'd0;
      tick_next    = 1'b1;
      hist_next    = {hist_reg[0], i_pin};
      if (hist_reg[0] == i_pin && i_pin != level_reg) begin
        level_next = i_pin;
        rise_next  = i_pin;
        fall_next  = ~i_pin;
      end
    end else begin
      div_cnt_next = div_cnt_reg + 3'd1;
    end
  end

  // Register the sampler state
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      div_cnt_reg <= 3'd0;
      hist_reg    <= 2'b00;
      level_reg   <= 1'b0;
      rise_reg    <= 1'b0;
      fall_reg    <= 1'b0;
      tick_reg    <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      hist_reg    <= hist_next;
      level_reg   <= level_next;
      rise_reg    <= rise_next;
      fall_reg    <= fall_next;
      tick_reg    <= tick_next;
    end
  end

  assign o_level       = level_reg;
  assign o_rise        = rise_reg;
  assign o_fall        = fall_reg;
  assign o_sample_tick = tick_reg;

endmodule

//--- hw/pwm_input_timer.sv
// Top of the PWM input measuring timer: prescaler, counter, capture and events.
//
// Summary of operation
// - 16-bit prescaled counter; wide timers go 32-bit.
// - Wide mode widens counter, period, capture to 32.
// - Wide enable bit only on wide timers.
// - Direction up, down or alternating up/down.
// - Period, prescaler and count mode are programmable.
// - Separate clock division sets filter sampling clock.
// - Repetition count exists only on advanced timers.
// - Per-source interrupt enables gate each interrupt.
// - External mode counts rising edges of the filtered input.
// - Active edge latches counter, raises capture interrupt.
// - Gated mode counts only at selected level.
`timescale 1ns/10ps
`include "pwm_timer_map.svh"

module pwm_input_timer
  import pwm_timer_pkg::*;
#(
  parameter bit WIDE_CAPABLE = 1'b1,   // Wide timer instance
  parameter bit ADVANCED     = 1'b0    // Advanced timer instance
) (
  input  wire logic                       i_clock,
  input  wire logic                       i_resetn,
  input  wire pwm_timer_pkg::timer_cfg_t  i_cfg,
  input  wire logic                       i_pin,
  input  wire logic                       i_trigger,
  input  wire pwm_timer_pkg::timer_flags_t i_flag_clear,
  output logic [31:0]                     o_counter_value,
  output logic [31:0]                     o_channel_data_value,
  output pwm_timer_pkg::timer_flags_t     o_flags,
  output logic                            o_update_irq,
  output logic                            o_trigger_irq,
  output logic                            o_capture_irq,
  output logic                            o_sample_tick
);
  import pwm_timer_pkg::*;

  // ----------------------------------------------------------------
  // Width helpers
  // ----------------------------------------------------------------
  // Effective wide mode: the bit is ignored on narrow timers
  function automatic logic eff_wide(input logic wide_bit);
    eff_wide = WIDE_CAPABLE & wide_bit;
  endfunction

  // Truncate a value to the active counter width
  function automatic logic [31:0] fit(input logic [31:0] v, input logic wide);
    fit = wide ? v : {16'h0000, v[15:0]};
  endfunction

  // ----------------------------------------------------------------
  // Input sampler
  // ----------------------------------------------------------------
  logic pin_level;   // Filtered input level
  logic pin_rise;    // Filtered rising edge
  logic pin_fall;    // Filtered falling edge
  logic tick;        // Sampling enable

  pwm_input_sampler #(.DIV_W(2)) u_sampler (
    .i_clock       (i_clock),
    .i_resetn      (i_resetn),
    .i_clk_div     (i_cfg.clk_div),
    .i_pin         (i_pin),
    .o_level       (pin_level),
    .o_rise        (pin_rise),
    .o_fall        (pin_fall),
    .o_sample_tick (tick)
  );

  // ----------------------------------------------------------------
  // Counter state
  // ----------------------------------------------------------------
  logic [15:0]  psc_reg,   psc_next;    // Prescaler count
  logic [31:0]  cnt_reg,   cnt_next;    // Counter value
  logic         down_reg,  down_next;   // Up/down phase
  logic [7:0]   rep_reg,   rep_next;    // Repetition count
  logic [31:0]  cap_reg,   cap_next;    // Channel data value
  timer_flags_t flag_reg,  flag_next;   // Sticky event flags
  logic         uirq_reg,  uirq_next;   // Update interrupt
  logic         tirq_reg,  tirq_next;   // Trigger interrupt
  logic         cirq_reg,  cirq_next;   // Capture interrupt
  logic         tick_reg;               // Registered sample tick

  logic         wide;       // Active wide mode
  logic [31:0]  period;     // Active period
  logic         step_src;   // Raw step before prescaling
  logic         step;       // Prescaled counter step
  logic         overflow;   // Period or zero reached
  logic         update_ev;  // Update event after repetition
  logic         cap_edge;   // Active capture edge

  // Pick the counting source and apply the prescaler
  always_comb begin
    wide      = eff_wide(i_cfg.wide_en);
    period    = fit(i_cfg.period, wide);
    cap_edge  = i_cfg.capture_en & (i_cfg.capture_rise ? pin_rise : pin_fall);
    case (i_cfg.clk_mode)
      SRC_EXTERNAL: step_src = pin_rise;
      SRC_GATED:    step_src = (pin_level == i_cfg.gate_level);
      default:      step_src = 1'b1;
    endcase
    step     = 1'b0;
    psc_next = psc_reg;
    if (i_cfg.count_en && step_src) begin
      if (psc_reg >= i_cfg.presc) begin
        psc_next = 16'h0000;
        step     = 1'b1;
      end else begin
        psc_next = psc_reg + 16'h0001;
      end
    end
  end

  // Counter, direction, repetition and update event
  always_comb begin
    cnt_next  = cnt_reg;
    down_next = down_reg;
    rep_next  = rep_reg;
    overflow  = 1'b0;
    update_ev = 1'b0;
    if (i_cfg.count_en && step) begin
      case (i_cfg.dir)
        DIR_UP: begin
          if (cnt_reg >= period) begin
            cnt_next = 32'h0;
            overflow = 1'b1;
          end else begin
            cnt_next = fit(cnt_reg + 32'h1, wide);
          end
        end
        DIR_DOWN: begin
          if (cnt_reg == 32'h0) begin
            cnt_next = period;
            overflow = 1'b1;
          end else begin
            cnt_next = fit(cnt_reg - 32'h1, wide); // Narrowing mid-count must not leave a high half
          end
        end
        default: begin
          // Turn around at both ends; each end is an update
          if (!down_reg) begin
            if (cnt_reg >= period) begin
              cnt_next  = (period == 32'h0) ? 32'h0 : period - 32'h1;
              down_next = 1'b1;
              overflow  = 1'b1;
            end else begin
              cnt_next = fit(cnt_reg + 32'h1, wide);
            end
          end else begin
            if (cnt_reg == 32'h0) begin
              cnt_next  = (period == 32'h0) ? 32'h0 : 32'h1;
              down_next = 1'b0;
              overflow  = 1'b1;
            end else begin
              cnt_next = fit(cnt_reg - 32'h1, wide);
            end
          end
        end
      endcase
    end else if (!wide) begin
      cnt_next = fit(cnt_reg, 1'b0); // Drop high half after narrowing
    end
    // Repetition only on advanced timers; others update on every overflow
    if (overflow) begin
      if (ADVANCED && rep_reg != 8'h00) begin
        rep_next = rep_reg - 8'h01;
      end else begin
        rep_next  = ADVANCED ? i_cfg.repeat_count : 8'h00;
        update_ev = 1'b1;
      end
    end
  end

  // Capture, flags and interrupt lines; a set wins over a clear
  always_comb begin
    cap_next  = cap_reg;
    flag_next = flag_reg & ~i_flag_clear;
    if (cap_edge) begin
      cap_next          = fit(cnt_reg, wide);
      flag_next.capture = 1'b1;
    end
    if (update_ev) begin
      flag_next.update = 1'b1;
    end
    if (i_trigger) begin
      flag_next.trigger = 1'b1;
    end
    uirq_next = flag_next.update  & i_cfg.ien_update;
    tirq_next = flag_next.trigger & i_cfg.ien_trigger;
    cirq_next = flag_next.capture & i_cfg.ien_capture;
  end

  // Register all timer state
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      psc_reg  <= 16'h0000;
      cnt_reg  <= 32'h0;
      down_reg <= 1'b0;
      rep_reg  <= 8'h00;
      cap_reg  <= 32'h0;
      flag_reg <= '0;
      uirq_reg <= 1'b0;
      tirq_reg <= 1'b0;
      cirq_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      psc_reg  <= psc_next;
      cnt_reg  <= cnt_next;
      down_reg <= down_next;
      rep_reg  <= rep_next;
      cap_reg  <= cap_next;
      flag_reg <= flag_next;
      uirq_reg <= uirq_next;
      tirq_reg <= tirq_next;
      cirq_reg <= cirq_next;
      tick_reg <= tick;
    end
  end

  assign o_counter_value      = cnt_reg;
  assign o_channel_data_value = cap_reg;
  assign o_flags              = flag_reg;
  assign o_update_irq         = uirq_reg;
  assign o_trigger_irq        = tirq_reg;
  assign o_capture_irq        = cirq_reg;
  assign o_sample_tick        = tick_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_hold_disabled;
    @(posedge i_clock) disable iff (!i_resetn)
      (!i_cfg.count_en && !$past(i_cfg.count_en) && $past(wide) == $past(wide, 2)) |-> $stable(cnt_reg);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) else $error("Counter moved while disabled");

  property p_narrow_range;
    @(posedge i_clock) disable iff (!i_resetn)
      !$past(wide) |-> (cnt_reg[31:16] == 16'h0000 && (WIDE_CAPABLE || cap_reg[31:16] == 16'h0000));
  endproperty
  a_narrow_range: assert property (p_narrow_range) else $error("Narrow timer exceeded 16 bits");

  property p_capture_latch;
    @(posedge i_clock) disable iff (!i_resetn)
      (cap_edge && wide) |=> (cap_reg == $past(cnt_reg) && flag_reg.capture);
  endproperty
  a_capture_latch: assert property (p_capture_latch) else $error("Capture did not latch counter");

  property p_update_flag;
    @(posedge i_clock) disable iff (!i_resetn)
      update_ev |=> flag_reg.update;
  endproperty
  a_update_flag: assert property (p_update_flag) else $error("Update flag not set");

  property p_up_reload;
    @(posedge i_clock) disable iff (!i_resetn)
      (step && i_cfg.dir == DIR_UP && cnt_reg >= period) |=> cnt_reg == 32'h0;
  endproperty
  a_up_reload: assert property (p_up_reload) else $error("Up counter did not reload");

  property p_irq_gate;
    @(posedge i_clock) disable iff (!i_resetn)
      !$past(i_cfg.ien_update) |-> !o_update_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("Update interrupt while disabled");

  property p_gated_hold;
    @(posedge i_clock) disable iff (!i_resetn)
      (i_cfg.clk_mode == SRC_GATED && pin_level != i_cfg.gate_level) |-> !step;
  endproperty
  a_gated_hold: assert property (p_gated_hold) else $error("Gated counter stepped at wrong level");

  property p_ext_edge;
    @(posedge i_clock) disable iff (!i_resetn)
      (i_cfg.clk_mode == SRC_EXTERNAL && !pin_rise) |-> !step;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("External mode stepped without edge");

  property p_down_step;
    @(posedge i_clock) disable iff (!i_resetn)
      (step && i_cfg.dir == DIR_DOWN && cnt_reg != 32'h0) |=> cnt_reg == fit($past(cnt_reg) - 32'h1, $past(wide));
  endproperty
  a_down_step: assert property (p_down_step) else $error("Down counter did not decrement");

  property p_tick_spacing;
    @(posedge i_clock) disable iff (!i_resetn)
      (tick && i_cfg.clk_div == 2'd1 && $past(i_cfg.clk_div) == 2'd1) |=> !tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("Sampling clock not divided");

endmodule

//--- test/pwm_source_model.sv
// Behavioural PWM source that drives the timer's measured input pin.
`timescale 1ns/10ps

module pwm_source_model (
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  input  wire logic       i_start,
  input  wire logic       i_idle_level,
  input  wire logic [7:0] i_count,
  input  wire logic [7:0] i_high_cycles,
  input  wire logic [7:0] i_low_cycles,
  output logic            o_pin,
  output logic            o_busy
);
  logic [7:0] pulses_left;  // Pulses still to send
  logic [7:0] phase_left;   // Cycles left in this phase
  logic       active;       // In the active phase

  // ----------------------------------------------------------------
  // Burst generator, moves on the falling edge like a real source
  // ----------------------------------------------------------------
  always @(negedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin <= i_idle_level;
      o_busy <= 1'b0;
      active <= 1'b0;
    end else if (!o_busy) begin
      // Idle line sits at the idle level the bench picks
      o_pin <= i_idle_level;
      if (i_start) begin
        o_busy <= 1'b1;
        active <= 1'b1;
        o_pin <= ~i_idle_level;
        pulses_left <= i_count;
        phase_left <= i_high_cycles;
      end
    end else if (phase_left > 8'h01) begin
      phase_left <= phase_left - 8'h01;
    end else if (active) begin
      // Slow or prompt pulses: widths come from the bench
      active <= 1'b0;
      o_pin <= i_idle_level;
      phase_left <= i_low_cycles;
    end else if (pulses_left > 8'h01) begin
      pulses_left <= pulses_left - 8'h01;
      active <= 1'b1;
      o_pin <= ~i_idle_level;
      phase_left <= i_high_cycles;
    end else begin
      o_busy <= 1'b0;
    end
  end
endmodule

//--- test/testbench.sv
// Self-checking bench for the PWM input measuring timer.
`timescale 1ns/10ps

module testbench;
  import pwm_timer_pkg::*;
  logic         i_clock;      // 10 MHz clock
  logic         i_resetn;     // Active low reset
  logic         i_trigger;    // Trigger pulse
  timer_cfg_t   cfg;          // Timer configuration
  timer_flags_t clr;          // Flag clear pulses
  logic         start;        // Source burst request
  logic         idle;         // Source idle level
  logic [7:0]   n_p;          // Pulses per burst
  logic [7:0]   hi;           // Active cycles
  logic [7:0]   lo;           // Idle cycles
  logic         pin;          // Measured input
  logic         busy;         // Source sending
  logic [31:0]  cnt;          // Counter value
  logic [31:0]  cap;          // Channel data value
  logic [31:0]  cnt_n;        // Counter of the narrow twin
  timer_flags_t flags;        // Sticky flags
  logic         irq_u;        // Update interrupt
  logic         irq_t;        // Trigger interrupt
  logic         irq_c;        // Capture interrupt
  logic         tick;         // Filter sample tick
  logic [31:0]  snap;         // Saved counter
  int           mismatches;   // Failed comparisons
  int           n_tests;      // All comparisons
  int           k;            // Loop counter
  int           ticks;        // Tick tally
  int           exp_ticks[4] = '{40, 20, 10, 10};

  pwm_source_model src (.i_clock(i_clock), .i_resetn(i_resetn), .i_start(start), .i_idle_level(idle),
    .i_count(n_p), .i_high_cycles(hi), .i_low_cycles(lo), .o_pin(pin), .o_busy(busy));

  pwm_input_timer #(.WIDE_CAPABLE(1'b1), .ADVANCED(1'b0)) dut (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_cfg(cfg), .i_pin(pin), .i_trigger(i_trigger), .i_flag_clear(clr), .o_counter_value(cnt),
    .o_channel_data_value(cap), .o_flags(flags), .o_update_irq(irq_u), .o_trigger_irq(irq_t),
    .o_capture_irq(irq_c), .o_sample_tick(tick));

  // Narrow twin on the same stimulus: its wide bit must have no effect
  pwm_input_timer #(.WIDE_CAPABLE(1'b0), .ADVANCED(1'b0)) dut_n (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_cfg(cfg), .i_pin(pin), .i_trigger(i_trigger), .i_flag_clear(clr), .o_counter_value(cnt_n),
    .o_channel_data_value(), .o_flags(), .o_update_irq(), .o_trigger_irq(), .o_capture_irq(),
    .o_sample_tick());

  // ----------------------------------------------------------------
  // Helpers; all stimulus lands on the falling edge
  // ----------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    check_word({31'h0, got}, {31'h0, exp}, what);
  endtask

  // Bounded waits, so a dead counter cannot hang the run
  task automatic wait_count(input logic [31:0] v);
    for (k = 0; k < 400 && cnt !== v; k++) cyc(1);
  endtask

  task automatic wait_flag(input int which);
    for (k = 0; k < 60 && flags[which] !== 1'b1; k++) cyc(1);
  endtask

  task automatic clear_all();
    clr = '1;
    cyc(1);
    clr = '0;
  endtask

  task automatic burst(input logic [7:0] n, input logic [7:0] h, input logic [7:0] l);
    n_p = n;
    hi = h;
    lo = l;
    // Non-blocking: the source moves on this same edge and must see one clean request
    start <= 1'b1;
    cyc(1);
    start <= 1'b0;
    cyc(1);
  endtask

  task automatic wait_quiet();
    for (k = 0; k < 900 && busy !== 1'b0; k++) cyc(1);
    cyc(10);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog: the whole sequence needs a few hundred cycles
  // ----------------------------------------------------------------
  initial begin
    #3_000_000;
    mismatches++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cfg = '0;
    cfg.gate_level = 1'b1;
    cfg.capture_rise = 1'b1;
    cfg.period = 32'h00000005;
    cfg.repeat_count = 8'h03;     // Ignored: no repetition on this timer
    clr = '0;
    i_trigger = 1'b0;
    start = 1'b0;
    idle = 1'b0;
    n_p = 8'h01;
    hi = 8'h04;
    lo = 8'h04;
    mismatches = 0;
    n_tests = 0;
    i_resetn = 1'b0;
    cyc(8);
    check_word(cnt | cap | {29'h0, flags}, 32'h0, "reset state");
    i_resetn = 1'b1;
    // Up count, period match, update flag and its enable
    cfg.ien_update = 1'b1;
    cfg.count_en = 1'b1;
    wait_count(32'h5);
    cyc(1);
    check_word(cnt, 32'h0, "up reload");
    check_bit(irq_u, 1'b1, "update irq");
    clear_all();
    check_bit(flags.update, 1'b0, "update clear");
    cfg.ien_update = 1'b0;
    wait_count(32'h5);
    cyc(1);
    check_bit(flags.update, 1'b1, "each overflow updates");
    check_bit(irq_u, 1'b0, "masked update irq");
    // Prescaler divides by presc+1
    cfg.presc = 16'h0003;
    snap = cnt;
    for (k = 0; k < 20 && cnt === snap; k++) cyc(1);
    snap = cnt;
    for (k = 0; k < 20 && cnt === snap; k++) cyc(1);
    check_word(k, 32'h4, "prescale steps");
    cfg.presc = 16'h0000;
    // Disabled counter holds
    cfg.count_en = 1'b0;
    cyc(2);
    snap = cnt;
    cyc(10);
    check_word(cnt, snap, "hold when off");
    // Down count; wide versus narrow reload of period
    cfg.count_en = 1'b1;
    cfg.dir = DIR_DOWN;
    cfg.period = 32'h00010007;
    cfg.wide_en = 1'b1;
    wait_count(32'h0);
    cyc(1);
    check_word(cnt, 32'h00010007, "wide reload");
    check_word(cnt_n, 32'h00000007, "narrow timer reload");
    cyc(1);
    check_word(cnt, 32'h00010006, "wide down");
    cfg.wide_en = 1'b0;
    wait_count(32'h0);
    cyc(1);
    check_word(cnt, 32'h00000007, "narrow reload");
    // Up/down turns at both ends; both encodings
    cfg.period = 32'h00000006;
    for (int d = 0; d < 2; d++) begin
      cfg.dir = d ? DIR_UPDOWN_ALT : DIR_UPDOWN;
      wait_count(32'h1);
      clear_all();
      wait_count(32'h6);
      clear_all();
      check_word(cnt, 32'h5, "turn at period");
      check_bit(flags.update, 1'b1, "turn update");
      wait_count(32'h0);
      cyc(1);
      check_word(cnt, 32'h1, "turn at zero");
    end
    // External clock: one count per rising input edge
    cfg.dir = DIR_UP;
    cfg.period = 32'h0000ffff;
    cfg.clk_mode = SRC_EXTERNAL;
    cyc(10);
    snap = cnt;
    burst(8'h05, 8'h04, 8'h04);
    wait_quiet();
    check_word(cnt, snap + 32'h5, "external edges");
    // Gated, high level counts
    cfg.clk_mode = SRC_GATED;
    cyc(10);
    snap = cnt;
    cyc(20);
    check_word(cnt, snap, "gate closed");
    burst(8'h01, 8'd40, 8'h01);
    wait_quiet();
    check_bit((cnt - snap) >= 32'd38 && (cnt - snap) <= 32'd42, 1'b1, "high gate span");
    // Gated, low level counts
    cfg.gate_level = 1'b0;
    cyc(5);
    snap = cnt;
    cyc(20);
    check_word(cnt, snap + 32'd20, "low gate open");
    burst(8'h01, 8'd40, 8'h01);
    cyc(8);
    snap = cnt;
    cyc(20);
    check_word(cnt, snap, "low gate closed");
    wait_quiet();
    // Capture on rising, then falling with irq masked
    cfg.clk_mode = SRC_INTERNAL;
    cfg.wide_en = 1'b1;
    cfg.period = 32'hffffffff;
    cfg.capture_en = 1'b1;
    cfg.ien_capture = 1'b1;
    clear_all();
    burst(8'h01, 8'd10, 8'd10);
    wait_flag(0);
    check_word(cap, cnt - 32'h1, "rise capture");
    check_bit(irq_c, 1'b1, "capture irq");
    clear_all();
    wait_quiet();
    check_bit(flags.capture, 1'b0, "no capture on fall");
    cfg.capture_rise = 1'b0;
    cfg.ien_capture = 1'b0;
    burst(8'h01, 8'd10, 8'd10);
    wait_flag(0);
    check_word(cap, cnt - 32'h1, "fall capture");
    check_bit(irq_c, 1'b0, "masked capture irq");
    wait_quiet();
    // Trigger flag with and without enable
    for (int e = 1; e >= 0; e--) begin
      cfg.ien_trigger = e[0];
      clear_all();
      i_trigger = 1'b1;
      cyc(1);
      i_trigger = 1'b0;
      wait_flag(1);
      check_bit(flags.trigger, 1'b1, "trigger flag");
      check_bit(irq_t, e[0], "trigger irq");
    end
    // Filter sampling rate per division code
    for (int c = 0; c < 4; c++) begin
      cfg.clk_div = c[1:0];
      cyc(8);
      ticks = 0;
      for (int t = 0; t < 40; t++) begin
        cyc(1);
        ticks += (tick === 1'b1);
      end
      check_word(ticks, exp_ticks[c], "sample ticks");
    end
    wrap_up();
  end
endmodule
